//--- design/bdmd_top.sv
`timescale 1ns/10ps
`include "bdmd_params.svh"

module bdmd_top
  import bdmd_pkg::*;
(
  input  wire logic           clk_sys,
  input  wire logic           rst,
  input  wire bdmd_core_req_t core_req,
  input  wire logic           load_bank_literal_instr,
  input  wire logic [3:0]     bank_literal,
  input  wire bdmd_usb_req_t  usb_req,
  input  wire logic           usb_enable,
  input  wire logic [3:0]     usb_max_endpoint,
  input  wire logic [1:0]     usb_ping_pong,
  input  wire logic           extended_set_enable,
  output logic      [7:0]     core_rdata,
  output logic                core_done,
  output logic      [11:0]    core_addr,
  output logic                core_bdt_hit,
  output logic      [3:0]     bank_pointer,
  output logic      [7:0]     usb_rdata,
  output logic                usb_done,
  output logic                cfg_error
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage and state

  logic [7:0]     general_purpose_ram [0:`BDMD_GPR_END];
  bdmd_state_t    cur;
  bdmd_state_t    next_cur;
  logic [11:0]    addr;
  bdmd_mode_t     mode;
  logic           core_in_gpr;
  logic           core_is_ptr;
  logic           core_we;
  logic           usb_in_gpr;
  logic           usb_we;
  logic [8:0]     bdt_entries;
  logic [10:0]    bdt_bytes;
  logic [11:0]    bdt_limit;
  logic [3:0]     addr_bank;

  ////////////////////////////////////////////////////////////////////////////
  // Address forming

  bdmd_addr_gen u_addr_gen (
    .full_move    (core_req.full_move),
    .access_sel   (core_req.access_sel),
    .offset       (core_req.offset),
    .full_addr    (core_req.full_addr),
    .bank_pointer (cur.bank_pointer),
    .addr         (addr),
    .mode         (mode)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Region decode

  always_comb begin
    addr_bank   = addr[11:8];
    core_in_gpr = (addr <= `BDMD_GPR_END);
    core_is_ptr = (addr == `BDMD_BANK_PTR_ADDR);
    core_we     = core_req.valid & core_req.write & core_in_gpr;
    usb_in_gpr  = (usb_req.addr <= `BDMD_GPR_END);
    usb_we      = usb_req.valid & usb_req.write & usb_in_gpr;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Descriptor table extent

  always_comb begin
    bdt_entries = {4'h0, usb_max_endpoint, 1'b0} + 9'h002;
    case (usb_ping_pong)
      `BDMD_PP_NONE: begin
        bdt_entries = {4'h0, usb_max_endpoint, 1'b0} + 9'h002;
      end
      `BDMD_PP_EP0_OUT: begin
        bdt_entries = bdt_entries + 9'h001;
      end
      `BDMD_PP_ALL: begin
        bdt_entries = {bdt_entries[7:0], 1'b0};
      end
      default: begin
        bdt_entries = {bdt_entries[7:0], 1'b0} - 9'h002;
      end
    endcase
    bdt_bytes = {bdt_entries, 2'b00};
    if (bdt_bytes > 11'h100) begin
      bdt_bytes = 11'h100;
    end
    bdt_limit = `BDMD_BDT_BASE + {1'b0, bdt_bytes};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_cur           = cur;
    next_cur.core_done = 1'b0;
    next_cur.usb_done  = 1'b0;
    next_cur.cfg_error = extended_set_enable;

    if (core_req.valid) begin
      next_cur.core_done = 1'b1;
      next_cur.core_addr = addr;
      next_cur.core_bdt_hit = 1'b0;
      if (usb_enable && (addr >= `BDMD_BDT_BASE) && (addr < bdt_limit)) begin
        next_cur.core_bdt_hit = 1'b1;
      end
      if (core_req.write) begin
        next_cur.core_rdata = `BDMD_RDATA_RST;
        if (core_is_ptr) begin
          next_cur.bank_pointer = core_req.wdata[3:0];
        end
      end else if (core_in_gpr) begin
        next_cur.core_rdata = general_purpose_ram[addr];
      end else if (core_is_ptr) begin
        next_cur.core_rdata = {4'h0, cur.bank_pointer};
      end else begin
        next_cur.core_rdata = `BDMD_RDATA_RST;
      end
    end

    if (load_bank_literal_instr) begin
      next_cur.bank_pointer = bank_literal;
    end

    if (usb_req.valid) begin
      next_cur.usb_done = 1'b1;
      if (usb_req.write) begin
        next_cur.usb_rdata = `BDMD_RDATA_RST;
      end else if (usb_in_gpr) begin
        next_cur.usb_rdata = general_purpose_ram[usb_req.addr];
      end else begin
        next_cur.usb_rdata = `BDMD_RDATA_RST;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cur <= '0;
      cur.bank_pointer <= `BDMD_BANK_PTR_RST;
    end else begin
      cur <= next_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // RAM write ports, no reset

  always_ff @(posedge clk_sys) begin
    if (usb_we) begin
      general_purpose_ram[usb_req.addr] <= usb_req.wdata;
    end
    if (core_we) begin
      general_purpose_ram[addr] <= core_req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign core_rdata   = cur.core_rdata;
  assign core_done    = cur.core_done;
  assign core_addr    = cur.core_addr;
  assign core_bdt_hit = cur.core_bdt_hit;
  assign bank_pointer = cur.bank_pointer;
  assign usb_rdata    = cur.usb_rdata;
  assign usb_done     = cur.usb_done;
  assign cfg_error    = cur.cfg_error;

endmodule

//--- design/bdmd_params.svh
`ifndef BDMD_PARAMS_SVH
`define BDMD_PARAMS_SVH

// Address space
`define BDMD_ADDR_W         12
`define BDMD_BANK_W         4
`define BDMD_OFS_W          8
`define BDMD_DATA_W         8
`define BDMD_BANKS          16
`define BDMD_BANK_SIZE      256

// Access bank map
`define BDMD_ACCESS_SPLIT   8'h60
`define BDMD_ACCESS_LO_BANK 4'h0
`define BDMD_ACCESS_HI_BANK 4'hF

// Region bounds
`define BDMD_GPR_BASE       12'h000
`define BDMD_GPR_END        12'hEBF
`define BDMD_SFR_BASE       12'hF40
`define BDMD_SFR_END        12'hFFF
`define BDMD_BANK_PTR_ADDR  12'hFE0
`define BDMD_BDT_BASE       12'h400
`define BDMD_BDT_END        12'h4FF

// Descriptor sizing
`define BDMD_BDT_ENTRY_SH   2
`define BDMD_PP_NONE        2'h0
`define BDMD_PP_EP0_OUT     2'h1
`define BDMD_PP_ALL         2'h2
`define BDMD_PP_ALL_BUT_EP0 2'h3

// Reset values
`define BDMD_BANK_PTR_RST   4'h0
`define BDMD_RDATA_RST      8'h00

`endif

//--- design/bdmd_pkg.sv
package bdmd_pkg;

  typedef enum logic [1:0] {
    BDMD_MODE_BANKED,
    BDMD_MODE_ACCESS,
    BDMD_MODE_FULL
  } bdmd_mode_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic       full_move;
    logic       access_sel;
    logic [7:0] offset;
    logic [11:0] full_addr;
    logic [7:0] wdata;
  } bdmd_core_req_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } bdmd_usb_req_t;

  typedef struct packed {
    logic [3:0]  bank_pointer;
    logic [7:0]  core_rdata;
    logic        core_done;
    logic [11:0] core_addr;
    logic        core_bdt_hit;
    logic [7:0]  usb_rdata;
    logic        usb_done;
    logic        cfg_error;
  } bdmd_state_t;

endpackage

//--- design/bdmd_addr_gen.sv
`timescale 1ns/10ps
`include "bdmd_params.svh"

module bdmd_addr_gen
  import bdmd_pkg::*;
(
  input  wire logic        full_move,
  input  wire logic        access_sel,
  input  wire logic [7:0]  offset,
  input  wire logic [11:0] full_addr,
  input  wire logic [3:0]  bank_pointer,
  output logic      [11:0] addr,
  output bdmd_mode_t       mode
);

  always_comb begin
    if (full_move) begin
      mode = BDMD_MODE_FULL;
      addr = full_addr;
    end else if (access_sel) begin
      mode = BDMD_MODE_BANKED;
      addr = {bank_pointer, offset};
    end else begin
      mode = BDMD_MODE_ACCESS;
      if (offset < `BDMD_ACCESS_SPLIT) begin
        addr = {`BDMD_ACCESS_LO_BANK, offset};
      end else begin
        addr = {`BDMD_ACCESS_HI_BANK, offset};
      end
    end
  end

endmodule

//--- tb/bdmd_chk.sv
`timescale 1ns/10ps
module bdmd_chk
  import bdmd_pkg::*;
(
  input wire logic           clk_sys,
  input wire logic           rst,
  input wire bdmd_core_req_t core_req,
  input wire logic           load_bank_literal_instr,
  input wire logic [3:0]     bank_literal,
  input wire bdmd_usb_req_t  usb_req,
  input wire logic           extended_set_enable,
  input wire logic [7:0]     core_rdata,
  input wire logic           core_done,
  input wire logic [11:0]    core_addr,
  input wire logic [3:0]     bank_pointer,
  input wire logic           usb_done,
  input wire logic           cfg_error
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_DONE: assert property (core_req.valid |=> core_done)
    else $error("core_done missing");
  AST_IDLE: assert property (!core_req.valid |=> !core_done)
    else $error("core_done without request");
  AST_ACC_LO: assert property (core_req.valid && !core_req.full_move && !core_req.access_sel
    && core_req.offset < 8'h60 |=> core_addr == {4'h0, $past(core_req.offset)}) else $error("access low map");
  AST_ACC_HI: assert property (core_req.valid && !core_req.full_move && !core_req.access_sel
    && core_req.offset >= 8'h60 |=> core_addr == {4'hF, $past(core_req.offset)}) else $error("access high map");
  AST_BANKED: assert property (core_req.valid && !core_req.full_move && core_req.access_sel
    |=> core_addr == {$past(bank_pointer), $past(core_req.offset)}) else $error("banked address");
  AST_FULL: assert property (core_req.valid && core_req.full_move
    |=> core_addr == $past(core_req.full_addr)) else $error("full address");
  AST_LIT: assert property (load_bank_literal_instr |=> bank_pointer == $past(bank_literal))
    else $error("literal load");
  AST_HOLE: assert property (core_req.valid && core_req.full_move && !core_req.write
    && core_req.full_addr > 12'hEBF && core_req.full_addr != 12'hFE0 |=> core_rdata == 8'h00)
    else $error("hole read not zero");
  AST_USB: assert property (usb_req.valid |=> usb_done)
    else $error("usb_done missing");
  AST_EXT: assert property (extended_set_enable |=> cfg_error)
    else $error("cfg_error missing");
endmodule
bind bdmd_top bdmd_chk i_chk (.*);

//--- tb/bdmd_usb_model.sv
`timescale 1ns/10ps
module bdmd_usb_model
  import bdmd_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       usb_done,
  input  wire logic [7:0] usb_rdata,
  output bdmd_usb_req_t   usb_req
);
  initial usb_req = '0;
  // One DMA byte; idle address and data lines show the inverted last value
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys);
    usb_req <= '{1'b1, w, a, d};
    @(posedge clk_sys);
    usb_req <= '{1'b0, w, ~a, ~d};
    #1 q = usb_done ? usb_rdata : 8'hEE;
  endtask
endmodule

//--- tb/tb_banked_data_memory_decode.sv
`timescale 1ns/10ps
module tb_banked_data_memory_decode
  import bdmd_pkg::*;
;
  logic           clk_sys = 0, rst = 1, lit = 0, usb_en = 0, ext = 0;
  logic [3:0]     lit_v = 4'h0, bank_pointer;
  bdmd_core_req_t core_req = '0;
  bdmd_usb_req_t  usb_req;
  logic [7:0]     core_rdata, usb_rdata;
  logic [11:0]    core_addr;
  logic           core_done, core_bdt_hit, usb_done, cfg_error;
  int             num_errors = 0, check_count = 0;
  always #20 clk_sys = ~clk_sys;
  bdmd_top i_dut (.clk_sys(clk_sys), .rst(rst), .core_req(core_req), .load_bank_literal_instr(lit),
    .bank_literal(lit_v), .usb_req(usb_req), .usb_enable(usb_en), .usb_max_endpoint(4'h0),
    .usb_ping_pong(2'h0), .extended_set_enable(ext), .core_rdata(core_rdata), .core_done(core_done),
    .core_addr(core_addr), .core_bdt_hit(core_bdt_hit), .bank_pointer(bank_pointer),
    .usb_rdata(usb_rdata), .usb_done(usb_done), .cfg_error(cfg_error));
  bdmd_usb_model i_usb (.clk_sys(clk_sys), .usb_done(usb_done), .usb_rdata(usb_rdata), .usb_req(usb_req));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic acc(input logic fm, as, w, input logic [7:0] of, input logic [11:0] fa, input logic [7:0] wd);
    @(posedge clk_sys);
    core_req <= '{1'b1, w, fm, as, of, fa, wd};
    @(posedge clk_sys);
    core_req <= '{1'b0, w, fm, as, ~of, ~fa, ~wd};
    #1 chk("core_done", 12'h001, 12'(core_done));
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    acc(1, 0, 0, 8'h00, a, 8'h00);
    chk("core_rdata", 12'(e), 12'(core_rdata));
  endtask
  task automatic load(input logic [3:0] v);
    @(posedge clk_sys);
    lit <= 1;
    lit_v <= v;
    @(posedge clk_sys);
    lit <= 0;
    lit_v <= ~v;
    #1 chk("bank_pointer", 12'(v), 12'(bank_pointer));
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic s_banked;
    load(4'h5);
    acc(0, 1, 1, 8'h12, 12'hFFF, 8'h3C);
    chk("core_addr", 12'h512, core_addr);
    rd(12'h512, 8'h3C);
    load(4'hF);
    acc(0, 1, 0, 8'h00, 12'h000, 8'h00);
    chk("core_rdata", 12'h000, 12'(core_rdata));
  endtask
  task automatic s_access;
    logic [7:0] o [4] = '{8'h00, 8'h5F, 8'h60, 8'hFF};
    for (int i = 0; i < 4; i++) begin
      acc(0, 0, 0, o[i], 12'h000, 8'h00);
      chk("access_addr", {(o[i] < 8'h60) ? 4'h0 : 4'hF, o[i]}, core_addr);
    end
  endtask
  task automatic s_ptr;
    acc(1, 0, 1, 8'h00, 12'hFE0, 8'hA7);
    chk("bank_pointer", 12'h007, 12'(bank_pointer));
    rd(12'hFE0, 8'h07);
    acc(1, 0, 1, 8'h00, 12'hEC5, 8'h55);
    rd(12'hEC5, 8'h00);
    acc(1, 0, 1, 8'h00, 12'h000, 8'h11);
    acc(1, 0, 1, 8'h00, 12'hEBF, 8'h66);
    rd(12'h000, 8'h11);
    rd(12'hEBF, 8'h66);
  endtask
  task automatic s_usb;
    logic [7:0] q;
    usb_en <= 1;
    acc(1, 0, 1, 8'h00, 12'h123, 8'h9A);
    i_usb.xfer(0, 12'h123, 8'h00, q);
    chk("usb_rdata", 12'h09A, 12'(q));
    i_usb.xfer(1, 12'h400, 8'h77, q);
    rd(12'h400, 8'h77);
    chk("core_bdt_hit", 12'h001, 12'(core_bdt_hit));
    i_usb.xfer(0, 12'hF00, 8'h00, q);
    chk("usb_rdata", 12'h000, 12'(q));
    usb_en <= 0;
    rd(12'h400, 8'h77);
    chk("core_bdt_hit", 12'h000, 12'(core_bdt_hit));
  endtask
  task automatic s_reset;
    acc(1, 0, 1, 8'h00, 12'h234, 8'hC3);
    @(posedge clk_sys);
    rst <= 1;
    repeat (2) @(posedge clk_sys);
    rst <= 0;
    rd(12'h234, 8'hC3);
  endtask
  task automatic s_ext;
    ext <= 1;
    acc(0, 0, 0, 8'h10, 12'h000, 8'h00);
    chk("access_addr", 12'h010, core_addr);
    chk("cfg_error", 12'h001, 12'(cfg_error));
    ext <= 0;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    wrap_up;
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 0;
    s_banked;
    s_access;
    s_ptr;
    s_usb;
    s_reset;
    s_ext;
    wrap_up;
  end
endmodule
